// file: dv/purge_plant.sv
// partner: pressure sensors seen by the sequencer, behind the enclosure
`timescale 1ns/1ps
module purge_plant (
    input wire logic supply_on,
    input wire logic enclosure_open,
    input wire logic [purge_pkg::PRESS_W-1:0] enc_level,
    input wire logic [purge_pkg::PRESS_W-1:0] flow_level,
    output logic [purge_pkg::PRESS_W-1:0] enclosure_pressure,
    output logic [purge_pkg::PRESS_W-1:0] purge_pressure
);
    // ------------------------------------------------------------
    // sensors
    // ------------------------------------------------------------
    // a dead supply zeroes both sensors, an open enclosure the enclosure one, never the old value
    always_comb begin
        enclosure_pressure = (supply_on && !enclosure_open) ? enc_level : '0;
        purge_pressure = supply_on ? flow_level : '0;
    end
endmodule : purge_plant

// file: dv/testbench.sv
// testbench: phase sequence scenarios for the purge sequencer
`timescale 1ns/1ps
module testbench;
    localparam logic [15:0] MIN_P = 16'h0064;
    localparam logic [15:0] PRE_P = 16'h0096;
    localparam logic [15:0] PURGE_P = 16'h0096;
    localparam logic [15:0] OPER_MAX = 16'h0190;
    localparam logic [15:0] PURGE_MAX = 16'h01F4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic supply_on = 1'b0;
    logic enc_open = 1'b0;
    logic [15:0] enc_level = 16'h00FA;
    logic [15:0] flow_level = 16'h00C8;
    logic [15:0] purge_time = 16'h02D0;
    logic [1:0] aux_cfg = 2'h1;
    logic prog_sw = 1'b0;
    logic [15:0] enc_p;
    logic [15:0] flow_p;
    logic valve;
    logic prealarm;
    logic rel;
    logic sw_off;
    logic prog_mode;
    logic [15:0] remain;
    logic [2:0] phase;
    purge_pkg::leds_s leds;
    purge_pkg::relays_s relays;
    int error_cnt = 0;
    int checked = 0;

    always #5 clk = ~clk;

    purge_plant u_purge_plant (.supply_on(supply_on),
        .enclosure_open(enc_open), .enc_level(enc_level),
        .flow_level(flow_level), .enclosure_pressure(enc_p),
        .purge_pressure(flow_p));

    purge_phase_sequencer u_purge_phase_sequencer (.CLK(clk), .RST(rst),
        .ENCLOSURE_PRESSURE(enc_p), .PURGE_PRESSURE(flow_p),
        .MIN_PRESSURE_THRESHOLD(MIN_P), .PREALARM_THRESHOLD(PRE_P),
        .PURGE_PRESSURE_THRESHOLD(PURGE_P),
        .OPERATE_MAX_PRESSURE(OPER_MAX), .PURGE_MAX_PRESSURE(PURGE_MAX),
        .PURGE_TIME_SEC(purge_time), .AUX_RELAY_CFG(aux_cfg),
        .PROG_SWITCH(prog_sw), .PURGE_VALVE(valve), .LEDS(leds),
        .RELAYS(relays), .PREALARM(prealarm), .RELEASE(rel),
        .SWITCH_OFF(sw_off), .PROG_MODE(prog_mode),
        .PURGE_REMAIN(remain), .PHASE(phase));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step

    // bounded wait, then the phase itself is compared by the caller
    task automatic wait_phase(input logic [2:0] exp, input int max);
        for (int i = 0; i < max; i++) begin
            if (phase === exp) break;
            @(negedge clk);
        end
    endtask : wait_phase

    task automatic print_verdict;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    initial begin
        #20000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        print_verdict();
    end

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        step(5);
        check(16'(phase), 16'(purge_pkg::PH_PREP), "reset phase");
        check(16'(relays), 16'(purge_pkg::RELAYS_OFF), "reset relays");
        step(5);
        rst = 1'b0;
        supply_on = 1'b1;
        enc_open = 1'b1;
        step(10);
        check(16'(leds), 16'(purge_pkg::LEDS_RESET), "initial leds");
        check(16'(phase), 16'(purge_pkg::PH_PREP), "open enclosure");
        prog_sw = 1'b1;
        enc_open = 1'b0;
        step(10);
        check(16'(prog_mode), 16'h0001, "prog mode on");
        check(16'(phase), 16'(purge_pkg::PH_PREP), "prog holds prep");
        check(16'(valve), 16'h0000, "valve shut in prog");
        prog_sw = 1'b0;
        wait_phase(purge_pkg::PH_PURGE, 10);
        check(16'(prog_mode), 16'h0000, "prog mode off");
        check(16'(phase), 16'(purge_pkg::PH_PURGE), "enter purge");
        check(16'(valve), 16'h0001, "valve open");
        check(16'(leds.min_pressure), 16'h0001, "min led");
        check(16'(leds.prealarm), 16'h0000, "prealarm led");
        step(5);
        check(16'(leds.purge_pressure), 16'h0001, "purge led");
        check(remain, 16'h02D0, "twelve minutes loaded");
        flow_level = 16'h0000;
        step(6);
        check(16'(leds.purge_pressure), 16'h0000, "purge led lost");
        check(16'(leds.operate), 16'h0000, "operate led lost");
        check(remain, 16'h02D0, "count halted");
        flow_level = 16'h00C8;
        enc_level = 16'h0258;
        step(6);
        check(16'(phase), 16'(purge_pkg::PH_PURGE), "over purge max");
        check(16'(valve), 16'h0001, "valve stays open");
        enc_level = 16'h0078;
        step(6);
        check(16'(prealarm), 16'h0001, "prealarm out");
        check(16'(sw_off), 16'h0000, "no switch-off yet");
        enc_level = 16'h0032;
        step(6);
        check(16'(phase), 16'(purge_pkg::PH_PREP), "back to prep");
        check(16'(valve), 16'h0000, "valve closed");
        check(16'(sw_off), 16'h0001, "switch-off");
        // zero purge time ends the countdown at once, sparing 720 seconds of 1e8 cycles each
        purge_time = 16'h0000;
        enc_level = 16'h00FA;
        wait_phase(purge_pkg::PH_OPER, 30);
        check(16'(phase), 16'(purge_pkg::PH_OPER), "enter operating");
        check(16'(valve), 16'h0000, "valve closed");
        check(16'(leds.purge_pressure), 16'h0000, "purge led off");
        check(16'({leds.min_pressure, leds.operate, leds.status}),
              16'h0007, "steady leds");
        check(16'(relays.mains_release_relay), 16'h0001, "mains");
        check(16'({relays.aux_relay_a, relays.aux_relay_b}),
              16'h0002, "aux per cfg");
        check(16'({relays.enclosure_load_relay, leds.enclosure_load}),
              16'h0003, "load relay on");
        check(16'(rel), 16'h0001, "release");
        step(7);
        check(16'(leds.operate), 16'h0001, "operate steady");
        aux_cfg = 2'h2;
        step(2);
        check(16'({relays.aux_relay_a, relays.aux_relay_b}),
              16'h0001, "aux b per cfg");
        enc_level = 16'h01C2;
        step(6);
        check(16'(rel), 16'h0000, "over operate max");
        check(16'(phase), 16'(purge_pkg::PH_OPER), "still operating");
        enc_level = 16'h00FA;
        flow_level = 16'h0000;
        step(6);
        check(16'({relays.enclosure_load_relay, leds.enclosure_load}),
              16'h0000, "load relay off");
        enc_level = 16'h0032;
        step(6);
        check(16'(rel), 16'h0000, "release withdrawn");
        check(16'(phase), 16'(purge_pkg::PH_PREP), "drop to prep");
        check(16'(relays.mains_release_relay), 16'h0000, "mains off");
        print_verdict();
    end
endmodule : testbench

// file: hdl/pressure_compare.sv
// module: synchronised threshold comparison of one pressure reading
`timescale 1ns/1ps
module pressure_compare (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [purge_pkg::PRESS_W-1:0] value,
    input wire logic [purge_pkg::PRESS_W-1:0] threshold,
    output logic above
);
    // ------------------------------------------------------------
    // two-stage capture, then compare
    // ------------------------------------------------------------
    logic [purge_pkg::PRESS_W-1:0] meta_q, meta_d;
    logic [purge_pkg::PRESS_W-1:0] sync_q, sync_d;
    logic above_q, above_d;

    // readings may be multi-bit and async; a sensor front end is assumed
    // to hold a reading stable for several cycles so skew settles out
    always_comb begin
        meta_d = value;
        sync_d = meta_q;
        above_d = sync_q > threshold;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            meta_q <= '0;
            sync_q <= '0;
            above_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            above_q <= above_d;
        end
    end

    assign above = above_q;

endmodule : pressure_compare

// file: hdl/purge_phase_sequencer.sv
// module: purge controller phase sequencer (prep, purge, operate)
`timescale 1ns/1ps
// Overview of operation
// [RL1] initial display: status and prealarm lit
// [RL2] above minimum: min LED on, prealarm off
// [RL3] minimum exceeded in prep: open valve, purge
// [RL4] purge pressure ok: LED, countdown, flash operate
// [RL5] count only with flow and below purge max
// [RL6] flow lost: halt count, LEDs off
// [RL7] countdown end: close valve, enter operating
// [RL8] operating: valve closed, steady indicators
// [RL9] operating entry: mains relay, aux per config
// [RL10] release only after purge, below operate max
// [RL11] below minimum in operating: withdraw release
// [RL12] load relay on after purge, off on loss
// [RL13] purge max monitored during purge time
// [RL14] programming switch off: enter control mode
// [RL15] configurer stores purge minutes and pressure; here they are inputs, purge time in seconds on PURGE_TIME_SEC
// [RL16] below minimum triggers switch-off
// [RL17] prealarm output below prealarm threshold
// [RL18] below minimum in purge: close valve, prep
// [RL19] synchronous evaluation, prep after reset
module purge_phase_sequencer (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [purge_pkg::PRESS_W-1:0] ENCLOSURE_PRESSURE,
    input wire logic [purge_pkg::PRESS_W-1:0] PURGE_PRESSURE,
    input wire logic [purge_pkg::PRESS_W-1:0] MIN_PRESSURE_THRESHOLD,
    input wire logic [purge_pkg::PRESS_W-1:0] PREALARM_THRESHOLD,
    input wire logic [purge_pkg::PRESS_W-1:0] PURGE_PRESSURE_THRESHOLD,
    input wire logic [purge_pkg::PRESS_W-1:0] OPERATE_MAX_PRESSURE,
    input wire logic [purge_pkg::PRESS_W-1:0] PURGE_MAX_PRESSURE,
    input wire logic [purge_pkg::TIME_W-1:0] PURGE_TIME_SEC,
    input wire logic [purge_pkg::AUX_N-1:0] AUX_RELAY_CFG,
    input wire logic PROG_SWITCH,
    output logic PURGE_VALVE,
    output purge_pkg::leds_s LEDS,
    output purge_pkg::relays_s RELAYS,
    output logic PREALARM,
    output logic RELEASE,
    output logic SWITCH_OFF,
    output logic PROG_MODE,
    output logic [purge_pkg::TIME_W-1:0] PURGE_REMAIN,
    output logic [2:0] PHASE
);
    // ------------------------------------------------------------
    // comparisons
    // ------------------------------------------------------------
    logic above_min, above_pre, above_purge, above_opmax, above_pgmax;

    pressure_compare u_min (.CLK(CLK), .RST(RST), .value(ENCLOSURE_PRESSURE),
        .threshold(MIN_PRESSURE_THRESHOLD), .above(above_min));
    pressure_compare u_pre (.CLK(CLK), .RST(RST), .value(ENCLOSURE_PRESSURE),
        .threshold(PREALARM_THRESHOLD), .above(above_pre));
    pressure_compare u_prg (.CLK(CLK), .RST(RST), .value(PURGE_PRESSURE),
        .threshold(PURGE_PRESSURE_THRESHOLD), .above(above_purge));
    pressure_compare u_opm (.CLK(CLK), .RST(RST), .value(ENCLOSURE_PRESSURE),
        .threshold(OPERATE_MAX_PRESSURE), .above(above_opmax));
    pressure_compare u_pgm (.CLK(CLK), .RST(RST), .value(ENCLOSURE_PRESSURE),
        .threshold(PURGE_MAX_PRESSURE), .above(above_pgmax));

    // ------------------------------------------------------------
    // programming switch synchroniser
    // ------------------------------------------------------------
    logic prog_meta_q, prog_meta_d, prog_q, prog_d;

    always_comb begin
        prog_meta_d = PROG_SWITCH;
        prog_d = prog_meta_q;
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            prog_meta_q <= 1'b1;
            prog_q <= 1'b1;
        end else begin
            prog_meta_q <= prog_meta_d;
            prog_q <= prog_d;
        end
    end

    // ------------------------------------------------------------
    // second time base and flash
    // ------------------------------------------------------------
    logic [purge_pkg::TICK_W-1:0] tick_q, tick_d;
    logic [purge_pkg::SEC_W-1:0] usec_q, usec_d;
    logic flash_q, flash_d;
    logic sec_pulse;

    always_comb begin
        tick_d = tick_q + 7'h01;
        usec_d = usec_q;
        flash_d = flash_q;
        sec_pulse = 1'b0;
        if (tick_q == purge_pkg::TICK_LAST) begin
            tick_d = '0;
            usec_d = usec_q + 20'h00001;
            if (usec_q == purge_pkg::SEC_LAST) begin
                usec_d = '0;
                sec_pulse = 1'b1;
                flash_d = ~flash_q;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tick_q <= '0;
            usec_q <= '0;
            flash_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            usec_q <= usec_d;
            flash_q <= flash_d;
        end
    end

    // ------------------------------------------------------------
    // phase machine and countdown
    // ------------------------------------------------------------
    purge_pkg::phase_e phase_q, phase_d;
    logic [purge_pkg::TIME_W-1:0] remain_q, remain_d;
    logic run_ok;

    // halted while in programming mode: no purge can start unconfigured
    assign run_ok = !prog_q;

    always_comb begin
        phase_d = phase_q;
        remain_d = remain_q;
        case (phase_q)
            purge_pkg::PH_PREP: begin
                remain_d = PURGE_TIME_SEC;
                if (run_ok && above_min) begin
                    phase_d = purge_pkg::PH_PURGE; // RL3
                end
            end
            purge_pkg::PH_PURGE: begin
                if (!run_ok || !above_min) begin
                    phase_d = purge_pkg::PH_PREP; // RL18
                end else if (remain_q == purge_pkg::TIME_ZERO) begin
                    phase_d = purge_pkg::PH_OPER; // RL7
                end else if (above_purge && !above_pgmax && sec_pulse) begin
                    remain_d = remain_q - purge_pkg::TIME_ONE; // RL4 RL5 RL13
                end
            end
            purge_pkg::PH_OPER: begin
                if (!run_ok || !above_min) begin
                    phase_d = purge_pkg::PH_PREP; // RL11 RL16
                end
            end
            default: begin
                phase_d = purge_pkg::PH_PREP;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            phase_q <= purge_pkg::PH_PREP; // RL19
            remain_q <= purge_pkg::TIME_ZERO;
        end else begin
            phase_q <= phase_d;
            remain_q <= remain_d;
        end
    end

    // ------------------------------------------------------------
    // outputs, registered
    // ------------------------------------------------------------
    purge_pkg::leds_s leds_q, leds_d;
    purge_pkg::relays_s relays_q, relays_d;
    logic valve_q, valve_d, release_q, release_d, pre_q, pre_d;
    logic soff_q, soff_d;
    logic in_oper, in_purge, flowing;

    always_comb begin
        in_oper = phase_d == purge_pkg::PH_OPER;
        in_purge = phase_d == purge_pkg::PH_PURGE;
        flowing = above_purge && !above_pgmax; // RL6
        leds_d = purge_pkg::LEDS_RESET;
        leds_d.status = 1'b1; // RL1
        leds_d.min_pressure = above_min; // RL2
        leds_d.prealarm = !above_min; // RL1 RL2
        leds_d.purge_pressure = in_purge && flowing; // RL4 RL6 RL7
        leds_d.operate = in_oper || (in_purge && flowing && flash_q); // RL8
        relays_d = purge_pkg::RELAYS_OFF;
        release_d = in_oper && !above_opmax; // RL10
        relays_d.mains_release_relay = release_d; // RL9
        relays_d.enclosure_load_relay = release_d && above_purge; // RL12
        relays_d.aux_relay_a = release_d && AUX_RELAY_CFG[0]; // RL9
        relays_d.aux_relay_b = release_d && AUX_RELAY_CFG[1];
        leds_d.enclosure_load = relays_d.enclosure_load_relay; // RL12
        valve_d = in_purge; // RL3 RL7 RL8
        pre_d = !above_pre; // RL17
        soff_d = !above_min; // RL16
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            leds_q <= purge_pkg::LEDS_RESET;
            relays_q <= purge_pkg::RELAYS_OFF;
            valve_q <= 1'b0;
            release_q <= 1'b0;
            pre_q <= 1'b1;
            soff_q <= 1'b1;
        end else begin
            leds_q <= leds_d;
            relays_q <= relays_d;
            valve_q <= valve_d;
            release_q <= release_d;
            pre_q <= pre_d;
            soff_q <= soff_d;
        end
    end

    assign LEDS = leds_q;
    assign RELAYS = relays_q;
    assign PURGE_VALVE = valve_q;
    assign RELEASE = release_q;
    assign PREALARM = pre_q;
    assign SWITCH_OFF = soff_q;
    assign PROG_MODE = prog_q; // RL14
    assign PURGE_REMAIN = remain_q;
    assign PHASE = phase_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_prep_after_reset: assert property (@(posedge CLK) // RL19
        $fell(RST) |-> phase_q == purge_pkg::PH_PREP)
        else $error("phase not prep after reset");
    a_purge_entry: assert property (@(posedge CLK) disable iff (RST) // RL3
        phase_q == purge_pkg::PH_PREP && !prog_q && above_min
        |=> phase_q == purge_pkg::PH_PURGE && PURGE_VALVE)
        else $error("purge not entered on min exceeded");
    a_count_halt: assert property (@(posedge CLK) disable iff (RST) // RL5
        phase_q == purge_pkg::PH_PURGE && (!above_purge || above_pgmax)
        |=> remain_q == $past(remain_q))
        else $error("countdown ran without flow");
    a_purge_done: assert property (@(posedge CLK) disable iff (RST) // RL7
        phase_q == purge_pkg::PH_PURGE && remain_q == purge_pkg::TIME_ZERO
        && above_min && !prog_q
        |=> phase_q == purge_pkg::PH_OPER && !PURGE_VALVE)
        else $error("operating not entered at count end");
    a_release_cause: assert property (@(posedge CLK) disable iff (RST) // RL10
        RELEASE |-> phase_q == purge_pkg::PH_OPER && !$past(above_opmax))
        else $error("release without completed purge");
    a_min_withdraw: assert property (@(posedge CLK) disable iff (RST) // RL11
        phase_q == purge_pkg::PH_OPER && !above_min |=> !RELEASE)
        else $error("release kept below minimum");
    a_prealarm_out: assert property (@(posedge CLK) disable iff (RST) // RL17
        !above_pre |=> PREALARM)
        else $error("prealarm not raised");
    a_load_relay: assert property (@(posedge CLK) disable iff (RST) // RL12
        RELAYS.enclosure_load_relay |-> LEDS.enclosure_load && RELEASE)
        else $error("load relay and its indicator disagree");
    a_flow_loss: assert property (@(posedge CLK) disable iff (RST) // RL6
        !above_purge |=> !LEDS.purge_pressure && !LEDS.operate
        || phase_q == purge_pkg::PH_OPER)
        else $error("purge indicators kept on flow loss");

endmodule : purge_phase_sequencer

// file: hdl/purge_pkg.sv
// package: phase codes, indicator/relay bundles and timing constants
package purge_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int TICK_US = 1_000_000;
    localparam int TICK_CYCLES = CLK_HZ / TICK_US;
    localparam int TICK_W = 7;
    localparam logic [TICK_W-1:0] TICK_LAST = 7'(TICK_CYCLES - 1);
    localparam int SEC_TICKS = 1_000_000;
    localparam int SEC_W = 20;
    localparam logic [SEC_W-1:0] SEC_LAST = 20'(SEC_TICKS - 1);
    localparam int FLASH_SECS_HALF = 1;
    localparam int TIME_W = 16;
    localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
    localparam logic [TIME_W-1:0] TIME_ONE = 16'h0001;
    localparam int PRESS_W = 16;
    localparam int AUX_N = 2;

    // ------------------------------------------------------------
    // phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_PREP = 3'b001,
        PH_PURGE = 3'b010,
        PH_OPER = 3'b100
    } phase_e;

    typedef struct packed {
        logic status;
        logic min_pressure;
        logic prealarm;
        logic purge_pressure;
        logic operate;
        logic enclosure_load;
    } leds_s;

    typedef struct packed {
        logic mains_release_relay;
        logic enclosure_load_relay;
        logic aux_relay_a;
        logic aux_relay_b;
    } relays_s;

    localparam leds_s LEDS_RESET = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    localparam relays_s RELAYS_OFF = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : purge_pkg
